// *** hdl/ppp_defines.svh ***
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
// ----------------------------------------
// Load action codes
// ----------------------------------------
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_NONE 2'h3
// ----------------------------------------
// Command bytes
// ----------------------------------------
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_CMD_NOP 8'h00
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define PPP_FUSE_LOW_RST 8'h62
`define PPP_FUSE_HIGH_RST 8'h99
`define PPP_FUSE_EXT_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_KEEP_EE_BIT 3
`define PPP_SIG_IDX1 8'h01
`define PPP_SIG_IDX2 8'h02
// ----------------------------------------
// Timing
// ----------------------------------------
`define PPP_CLK_NS 100
`define PPP_MIN_PULSE_NS 250
`define PPP_MIN_PULSE_CYC ((`PPP_MIN_PULSE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`endif

// *** hdl/ppp_pkg.sv ***
package ppp_pkg;
    // Operation sequencer, Gray coded along the erase path that includes eeprom erase
    typedef enum logic [2:0] {
        PPP_IDLE = 3'h0,
        PPP_ER_FLASH = 3'h1,
        PPP_ER_EEPROM = 3'h3,
        PPP_ER_LOCK = 3'h2,
        PPP_PROG = 3'h4
    } ppp_state_type;
endpackage

// *** hdl/ppp_port.sv ***
`timescale 1ns/1ps
`include "ppp_defines.svh"
module ppp_port #(
    parameter int WORD_BITS = 6,
    parameter int ERASE_CYC = 16,
    parameter int PROG_CYC = 16,
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // System
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link clock domain
    input wire logic load_strobe_clock,
    input wire logic load_action_sel0,
    input wire logic load_action_sel1,
    // Programmer strobes and selects
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic buffer_latch_strobe,
    input wire logic byte_pick_first,
    input wire logic byte_pick_second,
    // Data bus
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Status
    output logic prog_done_flag,
    // Memory array side
    output logic [15:0] nvm_addr,
    input wire logic [15:0] nvm_flash_rdata,
    input wire logic [7:0] nvm_eeprom_rdata,
    output logic nvm_erase_flash,
    output logic nvm_erase_eeprom,
    output logic nvm_page_write,
    input wire logic [WORD_BITS-1:0] pbuf_rd_idx,
    output logic [15:0] pbuf_rd_data,
    output logic [7:0] lock_bits,
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext
);
    localparam int PBUF_WORDS = 1 << WORD_BITS;
    localparam int CNT_W = 16;

    // ----------------------------------------
    // Link domain capture
    // ----------------------------------------
    logic link_rst_s1_reg, link_rst_s2_reg;
    logic link_tog_reg;
    logic [7:0] link_byte_reg;
    logic [1:0] link_act_reg;

    // Reset reaches the link side via the entry toggles of the clock
    always_ff @(posedge load_strobe_clock) begin
        link_rst_s1_reg <= rst;
        link_rst_s2_reg <= link_rst_s1_reg;
    end

    // Each positive pulse captures bus and action, then flags the event
    always_ff @(posedge load_strobe_clock) begin
        if (link_rst_s2_reg) begin
            link_tog_reg <= 1'b0;
            link_byte_reg <= 8'h00;
            link_act_reg <= `PPP_ACT_NONE;
        end else begin
            link_byte_reg <= data_in;
            link_act_reg <= {load_action_sel1, load_action_sel0};
            link_tog_reg <= ~link_tog_reg;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Order: toggle, byte pick second, byte pick first, latch, write
    localparam int NSYNC = 5;
    localparam logic [NSYNC-1:0] SYNC_RST = 5'h01;
    wire [NSYNC-1:0] pin_raw = {link_tog_reg, byte_pick_second, byte_pick_first,
                                buffer_latch_strobe, write_strobe_n};
    logic [NSYNC-1:0] pin_f;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic s1_reg, s2_reg, s3_reg, f_reg;
            // A change counts only once stages two and three agree
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg <= SYNC_RST[gi];
                    s2_reg <= SYNC_RST[gi];
                    s3_reg <= SYNC_RST[gi];
                    f_reg <= SYNC_RST[gi];
                end else if (ce) begin
                    s1_reg <= pin_raw[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) f_reg <= s3_reg;
                end
            end
            assign pin_f[gi] = f_reg;
        end
    endgenerate

    wire wr_n_f = pin_f[0];
    wire latch_f = pin_f[1];
    wire pick1_f = pin_f[2];
    wire pick2_f = pin_f[3];
    wire tog_f = pin_f[4];

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic wr_n_d_reg, latch_d_reg, tog_d_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_n_d_reg <= 1'b1;
            latch_d_reg <= 1'b0;
            tog_d_reg <= 1'b0;
        end else if (ce) begin
            wr_n_d_reg <= wr_n_f;
            latch_d_reg <= latch_f;
            tog_d_reg <= tog_f;
        end
    end

    wire wr_fall = ce & wr_n_d_reg & ~wr_n_f;
    wire latch_rise = ce & ~latch_d_reg & latch_f;
    // Bytes are stable by now: the link clock idles between pulses
    wire load_evt = ce & (tog_f != tog_d_reg);

    // ----------------------------------------
    // Command, address and data registers
    // ----------------------------------------
    ppp_pkg::ppp_state_type state_reg, state_next;
    logic [7:0] cmd_reg, addr_lo_reg, addr_hi_reg, data_lo_reg, data_hi_reg;
    logic write_armed_reg;

    wire idle = (state_reg == ppp_pkg::PPP_IDLE);
    wire is_write_cmd = (link_byte_reg == `PPP_CMD_ERASE) || (link_byte_reg == `PPP_CMD_WR_FUSE)
        || (link_byte_reg == `PPP_CMD_WR_LOCK) || (link_byte_reg == `PPP_CMD_WR_FLASH)
        || (link_byte_reg == `PPP_CMD_WR_EEPROM);
    wire ld_cmd = load_evt && (link_act_reg == `PPP_ACT_CMD);
    wire ld_addr = load_evt && (link_act_reg == `PPP_ACT_ADDR);
    wire ld_data = load_evt && (link_act_reg == `PPP_ACT_DATA);

    // Registers hold until reloaded, so one command serves many accesses
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_reg <= `PPP_CMD_NOP;
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            data_lo_reg <= 8'h00;
            data_hi_reg <= 8'h00;
            write_armed_reg <= 1'b0;
        end else begin
            if (ld_cmd) begin
                cmd_reg <= link_byte_reg;
                write_armed_reg <= is_write_cmd;
            end
            if (ld_addr && pick1_f) addr_hi_reg <= link_byte_reg;
            if (ld_addr && !pick1_f) addr_lo_reg <= link_byte_reg;
            if (ld_data && pick1_f) data_hi_reg <= link_byte_reg;
            if (ld_data && !pick1_f) data_lo_reg <= link_byte_reg;
        end
    end

    // High address and the low byte bits above WORD_BITS select the page, the low WORD_BITS bits the word within it
    assign nvm_addr = {addr_hi_reg, addr_lo_reg};

    // ----------------------------------------
    // Page buffer
    // ----------------------------------------
    logic [15:0] pbuf_mem [PBUF_WORDS];
    wire [WORD_BITS-1:0] word_idx = addr_lo_reg[WORD_BITS-1:0];
    wire pbuf_wr = latch_rise && write_armed_reg && (((cmd_reg == `PPP_CMD_WR_FLASH) && pick1_f)
        || (cmd_reg == `PPP_CMD_WR_EEPROM));

    // Whole page collected before one program operation
    always_ff @(posedge clk) begin
        if (pbuf_wr) pbuf_mem[word_idx] <= {data_hi_reg, data_lo_reg};
    end
    assign pbuf_rd_data = pbuf_mem[pbuf_rd_idx];

    // ----------------------------------------
    // Operation sequencer
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    wire keep_eeprom_on_erase = ~fuse_high[`PPP_KEEP_EE_BIT];
    wire step_done = (cnt_reg == CNT_W'(ERASE_CYC - 1));
    wire prog_done = (cnt_reg == CNT_W'(PROG_CYC - 1));
    wire wr_start = wr_fall && idle && write_armed_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ppp_pkg::PPP_IDLE: begin
                if (wr_start && (cmd_reg == `PPP_CMD_ERASE)) begin
                    state_next = ppp_pkg::PPP_ER_FLASH;
                end else if (wr_start) begin
                    state_next = ppp_pkg::PPP_PROG;
                end
            end
            ppp_pkg::PPP_ER_FLASH: begin
                if (step_done && keep_eeprom_on_erase) begin
                    state_next = ppp_pkg::PPP_ER_LOCK;
                end else if (step_done) begin
                    state_next = ppp_pkg::PPP_ER_EEPROM;
                end
            end
            ppp_pkg::PPP_ER_EEPROM: begin
                if (step_done) state_next = ppp_pkg::PPP_ER_LOCK;
            end
            ppp_pkg::PPP_ER_LOCK: state_next = ppp_pkg::PPP_IDLE;
            ppp_pkg::PPP_PROG: begin
                if (prog_done) state_next = ppp_pkg::PPP_IDLE;
            end
            default: state_next = ppp_pkg::PPP_IDLE;
        endcase
    end

    // State and step counter
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ppp_pkg::PPP_IDLE;
            cnt_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + CNT_W'(1);
        end
    end

    assign prog_done_flag = idle;
    assign nvm_erase_flash = (state_reg == ppp_pkg::PPP_ER_FLASH);
    assign nvm_erase_eeprom = (state_reg == ppp_pkg::PPP_ER_EEPROM);
    assign nvm_page_write = (state_reg == ppp_pkg::PPP_PROG)
        && ((cmd_reg == `PPP_CMD_WR_FLASH) || (cmd_reg == `PPP_CMD_WR_EEPROM));

    // ----------------------------------------
    // Fuse and lock bits
    // ----------------------------------------
    wire wr_fuse = wr_start && (cmd_reg == `PPP_CMD_WR_FUSE);
    // Fuses only change by their own command; erase never touches them
    always_ff @(posedge clk) begin
        if (rst) begin
            fuse_low <= `PPP_FUSE_LOW_RST;
            fuse_high <= `PPP_FUSE_HIGH_RST;
            fuse_ext <= `PPP_FUSE_EXT_RST;
            lock_bits <= `PPP_LOCK_RST;
        end else if (ce) begin
            if (wr_fuse && pick2_f) fuse_ext <= data_lo_reg;
            if (wr_fuse && !pick2_f && pick1_f) fuse_high <= data_lo_reg;
            if (wr_fuse && !pick2_f && !pick1_f) fuse_low <= data_lo_reg;
            // Writing only programs lock bits; erase alone restores them
            if (wr_start && (cmd_reg == `PPP_CMD_WR_LOCK)) lock_bits <= lock_bits & data_lo_reg;
            if (state_reg == ppp_pkg::PPP_ER_LOCK) lock_bits <= `PPP_LOCK_RST;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] sig_byte = (addr_lo_reg == `PPP_SIG_IDX1) ? SIG_BYTE1
        : (addr_lo_reg == `PPP_SIG_IDX2) ? SIG_BYTE2 : SIG_BYTE0;
    wire [7:0] fuse_rd = ({pick2_f, pick1_f} == 2'h0) ? fuse_low
        : ({pick2_f, pick1_f} == 2'h3) ? fuse_high
        : ({pick2_f, pick1_f} == 2'h2) ? fuse_ext : lock_bits;
    wire [7:0] rd_sel = (cmd_reg == `PPP_CMD_RD_SIG) ? (pick1_f ? CAL_BYTE : sig_byte)
        : (cmd_reg == `PPP_CMD_RD_FUSE) ? fuse_rd
        : (cmd_reg == `PPP_CMD_RD_FLASH) ? (pick1_f ? nvm_flash_rdata[15:8] : nvm_flash_rdata[7:0])
        : (cmd_reg == `PPP_CMD_RD_EEPROM) ? nvm_eeprom_rdata : 8'h00;

    // Data is refreshed every cycle with ce high so it is ready when the bus turns
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= 8'h00;
        end else if (ce) begin
            data_out <= rd_sel;
        end
    end

    // Enable follows the pin directly, avoiding contention on release
    assign data_oe = ~output_drive_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_erase_start;
        wr_start && (cmd_reg == `PPP_CMD_ERASE);
    endsequence
    sequence seq_busy_flash;
        !prog_done_flag && nvm_erase_flash;
    endsequence

    chk_erase_busy: assert property (seq_erase_start |=> seq_busy_flash)
        else $error("erase did not start busy");
    chk_lock_after_flash: assert property (nvm_erase_flash |=> $stable(lock_bits))
        else $error("lock bits changed before flash erase done");
    chk_eeprom_kept: assert property (nvm_erase_eeprom |-> !keep_eeprom_on_erase)
        else $error("eeprom erased while kept");
    chk_fuse_hold: assert property (!idle |=> $stable(fuse_high) && $stable(fuse_low))
        else $error("fuse changed during operation");
    chk_cmd_load: assert property (ld_cmd |=> cmd_reg == $past(link_byte_reg))
        else $error("command not loaded");
    chk_none_action: assert property (load_evt && link_act_reg == `PPP_ACT_NONE
        |=> $stable(cmd_reg) && $stable(addr_lo_reg) && $stable(data_lo_reg))
        else $error("idle action changed registers");
    chk_cmd_retain: assert property (!ld_cmd |=> $stable(cmd_reg))
        else $error("command changed without load");
    chk_nop_clear: assert property (ld_cmd && link_byte_reg == `PPP_CMD_NOP
        |=> !write_armed_reg)
        else $error("nop left write armed");
    chk_page_latch: assert property (pbuf_wr
        |=> pbuf_mem[$past(word_idx)] == {$past(data_hi_reg), $past(data_lo_reg)})
        else $error("page buffer word not latched");
    chk_prog_busy: assert property (wr_start && cmd_reg == `PPP_CMD_WR_FLASH
        |=> !prog_done_flag [*2])
        else $error("page program not busy");
endmodule // ppp_port

// *** verif/ppp_prog_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// External programmer model
// ----------------------------------------
module ppp_prog_model (
    // System
    input wire logic clk,
    // Link side
    output logic load_strobe_clock,
    output logic load_action_sel0,
    output logic load_action_sel1,
    // Strobes and selects
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic buffer_latch_strobe,
    output logic byte_pick_first,
    output logic byte_pick_second,
    // Data bus
    input wire logic [7:0] bus_seen,
    output logic [7:0] bus_drive
);
    // Entry pattern pins start at 0000, strobes inactive
    initial begin
        load_strobe_clock = 1'b0;
        {load_action_sel1, load_action_sel0} = 2'h0;
        {buffer_latch_strobe, byte_pick_first, byte_pick_second} = 3'h0;
        {write_strobe_n, output_drive_n} = 2'h3;
        bus_drive = 8'h00;
    end
    // One link clock cycle; the clock stands still between frames
    task automatic link_pulse();
        #20 load_strobe_clock = 1'b1;
        #7.5 load_strobe_clock = 1'b0;
        #7.5;
    endtask
    // Entry toggles; pattern pins are not touched meanwhile
    task automatic enter();
        repeat (6) begin
            @(posedge clk);
            link_pulse();
        end
    endtask
    // Selects go first, since the device filters them
    task automatic sel(input logic b1, input logic b2);
        @(posedge clk);
        byte_pick_first <= b1;
        byte_pick_second <= b2;
        repeat (6) @(posedge clk);
    endtask
    task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] val);
        sel(b1, byte_pick_second);
        {load_action_sel1, load_action_sel0} <= act;
        bus_drive <= val;
        link_pulse();
        @(posedge clk);
        bus_drive <= ~val; // Hold over: the bus stops showing the byte
        repeat (11) @(posedge clk); // Spacing lets the crossing see each load
    endtask
    task automatic strobe_wr();
        repeat (8) @(posedge clk); // Loads stay clear of the write strobe
        write_strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        write_strobe_n <= 1'b1;
    endtask
    task automatic latch();
        @(posedge clk);
        buffer_latch_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        buffer_latch_strobe <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic read(output logic [7:0] val);
        @(posedge clk);
        output_drive_n <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        val = bus_seen;
        @(posedge clk);
        output_drive_n <= 1'b1;
    endtask
endmodule // ppp_prog_model

// *** verif/ppp_port_tb.sv ***
`timescale 1ns/1ps
`include "ppp_defines.svh"
module ppp_port_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [7:0] SIG [3] = '{8'h1D, 8'h2E, 8'h4B}; // Arbitrary values
    localparam logic [7:0] CAL = 8'h77;
    localparam logic [15:0] FMASK = 16'hA55A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic lclk, sel0, sel1, wr_n, oe_n, latch_s, pk1, pk2, data_oe, prog_done_flag;
    logic er_fl, er_ee, pg_wr, mon_on, saw_busy, saw_fl, saw_ee, saw_pw, early;
    logic [7:0] bus_drive, data_out, lock_bits, fuse_low, fuse_high, fuse_ext, lock_prev, rd_val;
    logic [15:0] nvm_addr, pbuf_rd_data;
    logic [5:0] pbuf_rd_idx = 6'h00;
    wire [7:0] data_in = data_oe ? data_out : bus_drive;
    wire [15:0] flash_rd = nvm_addr ^ FMASK;
    wire [7:0] ee_rd = nvm_addr[7:0] ^ 8'h3C;
    int mismatches = 0;
    int checks = 0;
    initial mon_on = 1'b0;
    always #50 clk = ~clk;
    ppp_port #(.ERASE_CYC(8), .PROG_CYC(8), .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]),
        .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) u_dut (.clk(clk), .rst(rst), .ce(ce),
        .load_strobe_clock(lclk), .load_action_sel0(sel0), .load_action_sel1(sel1),
        .write_strobe_n(wr_n), .output_drive_n(oe_n), .buffer_latch_strobe(latch_s),
        .byte_pick_first(pk1), .byte_pick_second(pk2), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .prog_done_flag(prog_done_flag),
        .nvm_addr(nvm_addr), .nvm_flash_rdata(flash_rd), .nvm_eeprom_rdata(ee_rd),
        .nvm_erase_flash(er_fl), .nvm_erase_eeprom(er_ee), .nvm_page_write(pg_wr),
        .pbuf_rd_idx(pbuf_rd_idx), .pbuf_rd_data(pbuf_rd_data), .lock_bits(lock_bits),
        .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext));
    ppp_prog_model u_prog (.clk(clk), .load_strobe_clock(lclk), .load_action_sel0(sel0),
        .load_action_sel1(sel1), .write_strobe_n(wr_n), .output_drive_n(oe_n),
        .buffer_latch_strobe(latch_s), .byte_pick_first(pk1), .byte_pick_second(pk2),
        .bus_seen(data_in), .bus_drive(bus_drive));
    // Watch each write from strobe to ready; lock must hold while flash erases
    always @(negedge clk) begin
        if (mon_on) begin
            if (prog_done_flag === 1'b0) saw_busy = 1'b1;
            if (er_fl === 1'b1) saw_fl = 1'b1;
            if (er_ee === 1'b1) saw_ee = 1'b1;
            if (pg_wr === 1'b1) saw_pw = 1'b1;
            if (er_fl === 1'b1 && lock_bits !== lock_prev) early = 1'b1;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_write(input logic busy_exp);
        {saw_busy, saw_fl, saw_ee, saw_pw, early} = 5'h00;
        lock_prev = lock_bits;
        mon_on = 1'b1;
        u_prog.strobe_wr();
        repeat (6) @(negedge clk);
        for (int i = 0; i < 400 && prog_done_flag !== 1'b1; i++) @(negedge clk);
        mon_on = 1'b0;
        check(saw_busy, busy_exp);
        check(prog_done_flag, 1'b1);
    endtask
    task automatic rd(input logic b1, input logic b2, input logic [7:0] exp);
        u_prog.sel(b1, b2);
        u_prog.read(rd_val);
        check(rd_val, exp);
        #1 check(data_oe, 1'b0);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(prog_done_flag, 1'b1);
        check({fuse_low, fuse_high}, {`PPP_FUSE_LOW_RST, `PPP_FUSE_HIGH_RST});
        check({fuse_ext, lock_bits}, {`PPP_FUSE_EXT_RST, `PPP_LOCK_RST});
        check({er_fl, er_ee, pg_wr, data_oe}, 4'h0);
    endtask
    task automatic t_signature();
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'(i));
            rd(1'b0, 1'b0, SIG[i]);
        end
        u_prog.load(`PPP_ACT_NONE, 1'b0, 8'h00);
        rd(1'b0, 1'b0, SIG[2]);
        u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h00);
        rd(1'b1, 1'b0, CAL);
    endtask
    task automatic t_lock_read(input logic [31:0] exp);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
        u_prog.load(`PPP_ACT_DATA, 1'b0, 8'hF0);
        do_write(1'b1);
        check(lock_bits, 8'hF0);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FUSE);
        rd(1'b0, 1'b0, exp[31:24]);
        rd(1'b1, 1'b1, exp[23:16]);
        rd(1'b0, 1'b1, exp[15:8]);
        rd(1'b1, 1'b0, 8'hF0);
    endtask
    task automatic t_erase(input logic keep, input logic [23:0] fuses);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_ERASE);
        do_write(1'b1);
        check({saw_fl, saw_ee, early}, {1'b1, ~keep, 1'b0});
        check(lock_bits, `PPP_LOCK_RST);
        check({fuse_low, fuse_high}, fuses[23:8]);
        check(fuse_ext, fuses[7:0]);
    endtask
    task automatic t_fuse_write();
        logic [7:0] val [3];
        val = '{8'h5E, 8'hF7, 8'h91};
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FUSE);
        for (int i = 0; i < 3; i++) begin
            u_prog.load(`PPP_ACT_DATA, 1'b0, val[i]);
            u_prog.sel(i == 2, i == 1);
            do_write(1'b1);
        end
        check({fuse_low, fuse_high}, 16'h5E91);
        check(fuse_ext, 8'hF7);
        u_prog.sel(1'b0, 1'b0);
    endtask
    task automatic t_page();
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_FLASH);
        for (int w = 0; w < 2; w++) begin
            u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'hC5 + 8'(w));
            u_prog.load(`PPP_ACT_DATA, 1'b0, 8'hAB + 8'(w));
            u_prog.load(`PPP_ACT_DATA, 1'b1, 8'hCD + 8'(w));
            u_prog.latch();
        end
        for (int w = 0; w < 2; w++) begin
            @(posedge clk) pbuf_rd_idx <= 6'h05 + 6'(w);
            @(negedge clk) check(pbuf_rd_data, 16'hCDAB + 16'(w * 16'h0101));
        end
        u_prog.load(`PPP_ACT_ADDR, 1'b1, 8'h03);
        check(nvm_addr, 16'h03C6);
        do_write(1'b1);
        check({saw_pw, saw_fl}, 2'h2);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_NOP);
        do_write(1'b0);
        check(pg_wr, 1'b0);
    endtask
    task automatic t_read_mem();
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_FLASH);
        u_prog.load(`PPP_ACT_ADDR, 1'b1, 8'h12);
        u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h34);
        check(nvm_addr, 16'h1234);
        rd(1'b0, 1'b0, 8'h34 ^ FMASK[7:0]);
        rd(1'b1, 1'b0, 8'h12 ^ FMASK[15:8]);
        u_prog.load(`PPP_ACT_ADDR, 1'b0, 8'h35);
        rd(1'b0, 1'b0, 8'h35 ^ FMASK[7:0]);
        do_write(1'b0);
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_RD_EEPROM);
        rd(1'b0, 1'b0, 8'h35 ^ 8'h3C);
    endtask
    // A write strobe that falls and rises again while frozen is never seen
    task automatic t_freeze();
        u_prog.load(`PPP_ACT_CMD, 1'b0, `PPP_CMD_WR_LOCK);
        ce <= 1'b0;
        u_prog.strobe_wr();
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (12) @(posedge clk);
        check({prog_done_flag, lock_bits}, {1'b1, `PPP_LOCK_RST});
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        u_prog.enter();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Link side stays in reset for two more load clock edges
        repeat (2) u_prog.load(`PPP_ACT_NONE, 1'b0, 8'h00);
        repeat (500) @(posedge clk);
        @(negedge clk);
        t_reset();
        t_signature();
        t_lock_read({`PPP_FUSE_LOW_RST, `PPP_FUSE_HIGH_RST, `PPP_FUSE_EXT_RST, 8'h00});
        t_erase(1'b0, {`PPP_FUSE_LOW_RST, `PPP_FUSE_HIGH_RST, `PPP_FUSE_EXT_RST});
        t_fuse_write();
        t_lock_read({8'h5E, 8'h91, 8'hF7, 8'h00});
        t_erase(1'b1, 24'h5E91F7);
        t_page();
        t_read_mem();
        t_freeze();
        complete_run();
    end
    // Whole run needs well under 1 ms
    initial begin
        #1_000_000;
        mismatches++;
        complete_run();
    end
endmodule // ppp_port_tb
